// ==== rtl/gpcb_port.sv ====
// Eight-pin bidirectional port with pull-ups, analog selection and change detection.
`timescale 1ns/100ps
`default_nettype none
`include "gpcb_defines.svh"

// Operation
// RL1: Eight pins each have a direction bit; one tristates the driver, pin is input.
// RL2: Direction bit zero drives the pin with its output latch bit.
// RL3: Latch register reads return the stored latch value, not pin levels.
// RL4: Clearing bit 7 of the second control register enables all eight pull-ups; the code enables them on input pins only.
// RL5: A pin configured as output always has its pull-up switched off.
// RL6: After power-on reset all pull-ups are disabled.
// RL7: After reset upper three pins are digital; lower five analog, reading zero.
// RL8: Configuration strap chooses whether the lower five pins start analog or digital.
// RL9: Only upper four pins configured as inputs take part in change detection.
// RL10: Each participating pin is compared with its value captured at last port read.
// RL11: The four mismatches are ORed to set the change flag at bit 0.
// RL12: A standing mismatch keeps setting the change flag despite a clear.
// RL13: Any port access refreshes references, except when it is a move source.
// RL14: Software must access the port first, then clear the change flag.
// RL15: A change event can wake the device from sleep.
// RL16: Software should not poll the port while change detection is used.
// RL17: Analog selection disables the digital input buffer but not the output latch.
// RL18: With external transceiver enabled pins two and three carry its data outputs.
// RL19: Pins zero to two also feed external interrupt inputs zero to two.
// RL20: Low-voltage programming makes pin five the programming entry, nothing else.
// RL21: In programming or debug, pin six is serial clock, pin seven serial data; code takes them over in debug only, not in prog_mode.
module gpcb_port (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [`GPCB_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]             pwdata_i,
    input  wire logic [3:0]              pstrb_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    input  wire logic                    move_src_i,
    input  wire logic [7:0]              pad_in_i,
    output logic      [7:0]              pad_out_o,
    output logic      [7:0]              pad_oe_o,
    output logic      [7:0]              pad_pullup_o,
    input  wire logic                    cfg_low_pins_analog_at_por_i,
    input  wire logic                    cfg_low_volt_prog_enable_i,
    input  wire logic                    xcvr_ext_en_i,
    input  wire logic                    xcvr_minus_out_i,
    input  wire logic                    xcvr_plus_out_i,
    input  wire logic                    in_circuit_debug_en_i,
    input  wire logic                    serial_prog_data_out_i,
    input  wire logic                    serial_prog_data_oe_i,
    output logic                         serial_prog_clock_o,
    output logic                         serial_prog_data_o,
    output logic                         prog_mode_entry_o,
    output logic      [2:0]              ext_irq_in_o,
    output logic                         wake_o
);

    localparam int CL = `GPCB_CHG_LSB;

    gpcb_pkg::gpcb_byte_t pad_s1_r;
    gpcb_pkg::gpcb_byte_t pad_s2_r;
    logic [1:0]           cfg_s1_r;
    logic [1:0]           cfg_s2_r;

    gpcb_pkg::gpcb_byte_t output_latch_reg_r;
    gpcb_pkg::gpcb_byte_t direction_reg_r;
    gpcb_pkg::gpcb_byte_t third_int_ctrl_r;
    gpcb_pkg::gpcb_low_t  analog_sel_r;
    logic                 port_change_flag_r;
    logic                 port_change_irq_enable_r;
    logic                 pullup_disable_n_r;
    logic                 por_pending_r;
    gpcb_pkg::gpcb_nib_t  change_ref_r;

    logic                 acc;
    logic                 wr;
    logic                 rd;
    logic                 hit_port;
    logic                 mapped;
    gpcb_pkg::gpcb_byte_t pin_digital;
    gpcb_pkg::gpcb_byte_t func_off;
    gpcb_pkg::gpcb_nib_t  mismatch_bits;
    logic                 mismatch;
    logic                 prog_mode;
    gpcb_pkg::gpcb_byte_t oe_nxt;
    gpcb_pkg::gpcb_byte_t out_nxt;
    gpcb_pkg::gpcb_byte_t pull_nxt;
    logic [31:0]          rdata_nxt;

    // Pins arrive from outside the clock domain.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pad_s1_r <= 8'h00;
            pad_s2_r <= 8'h00;
        end else begin
            pad_s1_r <= pad_in_i;
            pad_s2_r <= pad_s1_r;
        end
    end

    // Straps run free through reset, so their level has settled when reset releases.
    always_ff @(posedge ref_clk_i) begin
        cfg_s1_r <= {cfg_low_volt_prog_enable_i, cfg_low_pins_analog_at_por_i};
        cfg_s2_r <= cfg_s1_r;
    end

    assign acc      = psel_i && penable_i;
    assign wr       = acc && pwrite_i && pstrb_i[0];
    assign rd       = acc && !pwrite_i;
    assign hit_port = paddr_i == `GPCB_OFF_PIN_LEVEL;
    assign mapped   = (paddr_i == `GPCB_OFF_PIN_LEVEL) || (paddr_i == `GPCB_OFF_LATCH) ||
                      (paddr_i == `GPCB_OFF_DIRECTION) || (paddr_i == `GPCB_OFF_PRIMARY) ||
                      (paddr_i == `GPCB_OFF_SECOND) || (paddr_i == `GPCB_OFF_THIRD) ||
                      (paddr_i == `GPCB_OFF_ANALOG_SEL);

    assign prog_mode = cfg_s2_r[1];

    // Pins whose normal port function is taken over by programming or debug.
    always_comb begin
        func_off                       = 8'h00;
        func_off[`GPCB_PIN_PROG_ENTRY] = prog_mode; // RL20
        func_off[`GPCB_PIN_PROG_CLOCK] = in_circuit_debug_en_i; // RL21
        func_off[`GPCB_PIN_PROG_DATA]  = in_circuit_debug_en_i; // RL21
    end

    // Analog pins and taken-over pins read as zero.
    assign pin_digital = pad_s2_r & ~{3'h0, analog_sel_r} & ~func_off; // RL7 RL17

    // Direction, latch and third control register storage.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            output_latch_reg_r <= `GPCB_RST_LATCH;
            direction_reg_r    <= `GPCB_RST_DIRECTION; // RL7
            third_int_ctrl_r   <= `GPCB_RST_THIRD;
        end else if (wr) begin
            if (hit_port || paddr_i == `GPCB_OFF_LATCH) begin
                output_latch_reg_r <= pwdata_i[7:0];
            end
            if (paddr_i == `GPCB_OFF_DIRECTION) begin
                direction_reg_r <= pwdata_i[7:0]; // RL1
            end
            if (paddr_i == `GPCB_OFF_THIRD) begin
                third_int_ctrl_r <= pwdata_i[7:0];
            end
        end
    end

    // The analog selection takes the strap one cycle after reset releases.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            analog_sel_r  <= `GPCB_RST_ANALOG_SEL; // RL7
            por_pending_r <= 1'b1;
        end else if (por_pending_r) begin
            analog_sel_r  <= {`GPCB_LOW_W{cfg_s2_r[0]}}; // RL8
            por_pending_r <= 1'b0;
        end else if (wr && paddr_i == `GPCB_OFF_ANALOG_SEL) begin
            analog_sel_r <= pwdata_i[4:0];
        end
    end

    // Pull-up control is active low and comes up disabled.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pullup_disable_n_r <= 1'b1; // RL6
        end else if (wr && paddr_i == `GPCB_OFF_SECOND) begin
            pullup_disable_n_r <= pwdata_i[`GPCB_BIT_PULLUP_N]; // RL4
        end
    end

    // A move that only reads the port leaves the references alone.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            change_ref_r <= 4'h0;
        end else if (acc && hit_port && !(rd && move_src_i)) begin
            change_ref_r <= pin_digital[CL +: `GPCB_CHG_W]; // RL10 RL13
        end
    end

    assign mismatch_bits = (pin_digital[CL +: `GPCB_CHG_W] ^ change_ref_r) &
                           direction_reg_r[CL +: `GPCB_CHG_W]; // RL9 RL10
    assign mismatch      = |mismatch_bits; // RL11

    // Set wins over a software clear, so a standing mismatch keeps the flag up.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            port_change_flag_r       <= 1'b0;
            port_change_irq_enable_r <= 1'b0;
        end else begin
            if (mismatch) begin
                port_change_flag_r <= 1'b1; // RL11 RL12
            end else if (wr && paddr_i == `GPCB_OFF_PRIMARY) begin
                port_change_flag_r <= pwdata_i[`GPCB_BIT_CHG_FLAG];
            end
            if (wr && paddr_i == `GPCB_OFF_PRIMARY) begin
                port_change_irq_enable_r <= pwdata_i[`GPCB_BIT_CHG_IE];
            end
        end
    end

    // Pin drive, after the alternate-function overrides.
    always_comb begin
        oe_nxt   = ~direction_reg_r; // RL1
        out_nxt  = output_latch_reg_r; // RL2
        pull_nxt = {8{~pullup_disable_n_r}} & direction_reg_r; // RL4 RL5
        if (xcvr_ext_en_i) begin
            oe_nxt[`GPCB_PIN_XCVR_MINUS]  = 1'b1; // RL18
            oe_nxt[`GPCB_PIN_XCVR_PLUS]   = 1'b1; // RL18
            out_nxt[`GPCB_PIN_XCVR_MINUS] = xcvr_minus_out_i; // RL18
            out_nxt[`GPCB_PIN_XCVR_PLUS]  = xcvr_plus_out_i; // RL18
            pull_nxt[`GPCB_PIN_XCVR_MINUS] = 1'b0;
            pull_nxt[`GPCB_PIN_XCVR_PLUS]  = 1'b0;
        end
        if (prog_mode) begin
            oe_nxt[`GPCB_PIN_PROG_ENTRY]   = 1'b0; // RL20
            pull_nxt[`GPCB_PIN_PROG_ENTRY] = 1'b0; // RL20
        end
        if (in_circuit_debug_en_i) begin
            oe_nxt[`GPCB_PIN_PROG_CLOCK]   = 1'b0; // RL21
            pull_nxt[`GPCB_PIN_PROG_CLOCK] = 1'b0; // RL21
            oe_nxt[`GPCB_PIN_PROG_DATA]    = serial_prog_data_oe_i; // RL21
            out_nxt[`GPCB_PIN_PROG_DATA]   = serial_prog_data_out_i; // RL21
            pull_nxt[`GPCB_PIN_PROG_DATA]  = 1'b0; // RL21
        end
    end

    // Outputs are registered, so pins follow the registers one cycle later.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pad_oe_o     <= 8'h00;
            pad_out_o    <= 8'h00;
            pad_pullup_o <= 8'h00;
        end else begin
            pad_oe_o     <= oe_nxt;
            pad_out_o    <= out_nxt;
            pad_pullup_o <= pull_nxt;
        end
    end

    // Alternate inputs see the synchronised pad regardless of analog selection.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ext_irq_in_o        <= 3'h0;
            prog_mode_entry_o   <= 1'b0;
            serial_prog_clock_o <= 1'b0;
            serial_prog_data_o  <= 1'b0;
            wake_o              <= 1'b0;
        end else begin
            ext_irq_in_o        <= pad_s2_r[2:0]; // RL19
            prog_mode_entry_o   <= prog_mode && pad_s2_r[`GPCB_PIN_PROG_ENTRY]; // RL20
            serial_prog_clock_o <= in_circuit_debug_en_i && pad_s2_r[`GPCB_PIN_PROG_CLOCK]; // RL21
            serial_prog_data_o  <= in_circuit_debug_en_i && pad_s2_r[`GPCB_PIN_PROG_DATA]; // RL21
            wake_o              <= port_change_flag_r && port_change_irq_enable_r; // RL15
        end
    end

    // Read mux.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (paddr_i)
            `GPCB_OFF_PIN_LEVEL:  rdata_nxt[7:0] = pin_digital;
            `GPCB_OFF_LATCH:      rdata_nxt[7:0] = output_latch_reg_r; // RL3
            `GPCB_OFF_DIRECTION:  rdata_nxt[7:0] = direction_reg_r;
            `GPCB_OFF_PRIMARY: begin
                rdata_nxt[`GPCB_BIT_CHG_FLAG] = port_change_flag_r;
                rdata_nxt[`GPCB_BIT_CHG_IE]   = port_change_irq_enable_r;
            end
            `GPCB_OFF_SECOND:     rdata_nxt[`GPCB_BIT_PULLUP_N] = pullup_disable_n_r;
            `GPCB_OFF_THIRD:      rdata_nxt[7:0] = third_int_ctrl_r;
            `GPCB_OFF_ANALOG_SEL: rdata_nxt[4:0] = analog_sel_r;
            default:              rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Zero-wait slave: data and error are registered in the setup cycle.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= 1'b1;
            if (psel_i && !penable_i) begin
                prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata_nxt;
                pslverr_o <= !mapped;
            end else if (!psel_i) begin
                pslverr_o <= 1'b0;
            end
        end
    end

    latch_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL3
        (psel_i && !penable_i && !pwrite_i && paddr_i == `GPCB_OFF_LATCH) |=>
        prdata_o[7:0] == $past(output_latch_reg_r))
        else $error("latch read did not return latch");

    drive_dir_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL1
        (!xcvr_ext_en_i && !in_circuit_debug_en_i && !prog_mode) |=>
        pad_oe_o == ~$past(direction_reg_r))
        else $error("output enable not inverse of direction");

    drive_latch_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL2
        (!xcvr_ext_en_i && !in_circuit_debug_en_i) |=>
        pad_out_o == $past(output_latch_reg_r))
        else $error("pin value differs from latch");

    pullup_out_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL5
        (pad_pullup_o & pad_oe_o) == 8'h00)
        else $error("pull-up on while driving");

    pullup_ctrl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL4
        pullup_disable_n_r |=> pad_pullup_o == 8'h00)
        else $error("pull-up on while disabled");

    pullup_por_a: assert property (@(posedge ref_clk_i) // RL6
        $fell(rst_i) |-> pad_pullup_o == 8'h00 && pullup_disable_n_r)
        else $error("pull-ups on after reset");

    flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL12
        mismatch |=> port_change_flag_r)
        else $error("flag not set on mismatch");

    no_spurious_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL11
        (!$past(port_change_flag_r) && !$past(mismatch) &&
         !($past(wr) && $past(paddr_i) == `GPCB_OFF_PRIMARY)) |-> !port_change_flag_r)
        else $error("flag set without cause");

    ref_refresh_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL13
        (acc && hit_port && !(rd && move_src_i)) |=> !mismatch || $changed(pad_s2_r))
        else $error("port access did not end mismatch");

    out_excl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL9
        (direction_reg_r[7:4] == 4'h0) |-> !mismatch)
        else $error("output pin caused mismatch");

    analog_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL17
        (pin_digital[4:0] & analog_sel_r) == 5'h00)
        else $error("analog pin read nonzero");

    wake_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL15
        (port_change_flag_r && port_change_irq_enable_r) |=> wake_o)
        else $error("wake not raised");

    ext_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL19
        1'b1 |=>
        ext_irq_in_o == $past(pad_s2_r[2:0]))
        else $error("external interrupt input not following pins");

    prog_entry_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL20
        !prog_mode |=>
        !prog_mode_entry_o)
        else $error("programming entry active without strap");

    serial_pins_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL21
        in_circuit_debug_en_i |=> !pad_oe_o[`GPCB_PIN_PROG_CLOCK] &&
        pad_oe_o[`GPCB_PIN_PROG_DATA] == $past(serial_prog_data_oe_i))
        else $error("serial pins not taken over");

    xcvr_drive_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL18
        xcvr_ext_en_i |=> pad_oe_o[3:2] == 2'b11 &&
        pad_out_o[3:2] == $past({xcvr_plus_out_i, xcvr_minus_out_i}))
        else $error("transceiver outputs not driven");

    ref_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL13
        (rd && hit_port && move_src_i) |=>
        $stable(change_ref_r))
        else $error("move source refreshed references");

    por_strap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL8
        por_pending_r |=>
        analog_sel_r == {`GPCB_LOW_W{$past(cfg_s2_r[0])}})
        else $error("analog selection not taken from strap");

endmodule
`default_nettype wire

// ==== rtl/gpcb_defines.svh ====
// Register offsets, field positions, reset values and widths of the change-detect port.
`ifndef GPCB_DEFINES_SVH
`define GPCB_DEFINES_SVH

`define GPCB_ADDR_W          12
`define GPCB_PORT_W          8
`define GPCB_LOW_W           5
`define GPCB_CHG_LSB         4
`define GPCB_CHG_W           4

`define GPCB_OFF_PIN_LEVEL   12'h000
`define GPCB_OFF_LATCH       12'h004
`define GPCB_OFF_DIRECTION   12'h008
`define GPCB_OFF_PRIMARY     12'h00c
`define GPCB_OFF_SECOND      12'h010
`define GPCB_OFF_THIRD       12'h014
`define GPCB_OFF_ANALOG_SEL  12'h018

`define GPCB_BIT_CHG_FLAG    0
`define GPCB_BIT_CHG_IE      3
`define GPCB_BIT_PULLUP_N    7

`define GPCB_PIN_XCVR_MINUS  2
`define GPCB_PIN_XCVR_PLUS   3
`define GPCB_PIN_PROG_ENTRY  5
`define GPCB_PIN_PROG_CLOCK  6
`define GPCB_PIN_PROG_DATA   7

`define GPCB_RST_LATCH       8'h00
`define GPCB_RST_DIRECTION   8'hff
`define GPCB_RST_THIRD       8'h00
`define GPCB_RST_ANALOG_SEL  5'h1f

`endif

// ==== rtl/gpcb_pkg.sv ====
// Types shared by the change-detect port.
package gpcb_pkg;
    typedef logic [7:0] gpcb_byte_t;
    typedef logic [3:0] gpcb_nib_t;
    typedef logic [4:0] gpcb_low_t;
endpackage

// ==== testbench/gpcb_pin_model.sv ====
// Pin-side model: external keys, weak pull-ups and floating lines of the port.
`timescale 1ns/100ps
`default_nettype none
module gpcb_pin_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pad_out_i,
    input  wire logic [7:0] pad_oe_i,
    input  wire logic [7:0] pad_pullup_i,
    input  wire logic [7:0] key_en_i,
    input  wire logic [7:0] key_val_i,
    output logic      [7:0] pad_in_o
);
    logic [7:0] float_r = 8'h00;

    // A line nobody drives toggles, so a stale level can never pass a check.
    always_ff @(posedge clk_i) begin
        float_r <= ~float_r;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe_i[i]) begin
                pad_in_o[i] = pad_out_i[i];
            end else if (key_en_i[i]) begin
                pad_in_o[i] = key_val_i[i];
            end else if (pad_pullup_i[i]) begin
                pad_in_o[i] = 1'b1;
            end else begin
                pad_in_o[i] = float_r[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_gpcb_port.sv ====
// Self-checking bench of the change-detect port.
`timescale 1ns/100ps
`default_nettype none
module tb_gpcb_port;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, move_src = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, slverr_seen;
    logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup;
    logic [7:0]  key_en = 8'hff, key_val = 8'hff;
    logic        cfg_analog = 1'b1, cfg_lvp = 1'b0, xcvr_en = 1'b0, xcvr_m = 1'b0;
    logic        xcvr_p = 1'b0, icd_en = 1'b0, sp_out = 1'b0, sp_oe = 1'b0;
    logic        sp_clk, sp_data, prog_entry, wake;
    logic [2:0]  ext_irq;
    int          miscompares = 0;
    int          cmp_count = 0;

    gpcb_port i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(4'h1), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .move_src_i(move_src), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .pad_pullup_o(pad_pullup), .cfg_low_pins_analog_at_por_i(cfg_analog),
        .cfg_low_volt_prog_enable_i(cfg_lvp), .xcvr_ext_en_i(xcvr_en),
        .xcvr_minus_out_i(xcvr_m), .xcvr_plus_out_i(xcvr_p), .in_circuit_debug_en_i(icd_en),
        .serial_prog_data_out_i(sp_out), .serial_prog_data_oe_i(sp_oe),
        .serial_prog_clock_o(sp_clk), .serial_prog_data_o(sp_data),
        .prog_mode_entry_o(prog_entry), .ext_irq_in_o(ext_irq), .wake_o(wake));

    gpcb_pin_model i_pins (.clk_i(ref_clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
        .pad_pullup_i(pad_pullup), .key_en_i(key_en), .key_val_i(key_val), .pad_in_o(pad_in));

    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The slave may stretch the access phase; only the watchdog ends a wait.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        q = prdata;
        slverr_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, {24'h0, exp});
    endtask

    task automatic settle();
        repeat (6) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic t_reset();
        settle();
        check(pad_pullup, 8'h00);
        check(pad_oe, 8'h00);
        rd_chk(12'h008, 8'hff);
        rd_chk(12'h004, 8'h00);
        rd_chk(12'h018, 8'h1f);
        rd_chk(12'h010, 8'h80);
        rd_chk(12'h014, 8'h00);
        rd_chk(12'h000, 8'he0);
        rd_chk(12'h01c, 8'h00);
        check(slverr_seen, 1'b1);
    endtask

    task automatic t_drive();
        key_val <= 8'h5a;
        wr(12'h004, 8'hb5);
        wr(12'h008, 8'h0f);
        settle();
        check(pad_oe, 8'hf0);
        check(pad_out & 8'hf0, 8'hb0);
        check(pad_out[4], 1'b1);
        rd_chk(12'h004, 8'hb5);
        rd_chk(12'h000, 8'ha0);
    endtask

    task automatic t_pullup();
        key_en <= 8'h00;
        wr(12'h008, 8'hff);
        wr(12'h010, 8'h00);
        settle();
        check(pad_pullup, 8'hff);
        rd_chk(12'h000, 8'he0);
        wr(12'h008, 8'h0f);
        settle();
        check(pad_pullup, 8'h0f);
        key_en <= 8'hff;
        wr(12'h010, 8'h80);
        wr(12'h008, 8'hff);
        settle();
        check(pad_pullup, 8'h00);
    endtask

    task automatic t_change();
        key_val <= 8'h00;
        settle();
        rd_chk(12'h000, 8'h00);
        wr(12'h00c, 8'h08);
        key_val <= 8'h80;
        settle();
        check(wake, 1'b1);
        rd_chk(12'h00c, 8'h09);
        rd_chk(12'h000, 8'h80);
        wr(12'h00c, 8'h00);
        rd_chk(12'h00c, 8'h00);
        key_val <= 8'h00;
        settle();
        wr(12'h00c, 8'h00);
        rd_chk(12'h00c, 8'h01);
        move_src <= 1'b1;
        rd_chk(12'h000, 8'h00);
        move_src <= 1'b0;
        wr(12'h00c, 8'h00);
        rd_chk(12'h00c, 8'h01);
        rd_chk(12'h000, 8'h00);
        wr(12'h00c, 8'h00);
        rd_chk(12'h00c, 8'h00);
        wr(12'h004, 8'h00);
        wr(12'h008, 8'h7f);
        rd_chk(12'h000, 8'h00);
        wr(12'h004, 8'h80);
        settle();
        rd_chk(12'h00c, 8'h00);
        wr(12'h008, 8'hff);
    endtask

    task automatic t_override();
        key_val <= 8'h25;
        cfg_lvp <= 1'b1;
        settle();
        check(ext_irq, 3'b101);
        check(prog_entry, 1'b1);
        rd_chk(12'h000, 8'h00);
        xcvr_en <= 1'b1;
        xcvr_m <= 1'b1;
        icd_en <= 1'b1;
        sp_oe <= 1'b1;
        sp_out <= 1'b1;
        key_val <= 8'h40;
        settle();
        check(pad_oe[3:2], 2'b11);
        check(pad_out[3:2], 2'b01);
        check(sp_clk, 1'b1);
        check({pad_oe[7], pad_out[7]}, 2'b11);
        check(sp_data, 1'b1);
        @(posedge ref_clk_i);
        {xcvr_en, xcvr_m, icd_en, sp_oe, sp_out, cfg_lvp} <= 6'h00;
    endtask

    // A second reset with the strap cleared must bring the low pins up digital.
    task automatic t_strap();
        cfg_analog <= 1'b0;
        rst_i <= 1'b1;
        key_val <= 8'h5a;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        settle();
        rd_chk(12'h000, 8'h5a);
        rd_chk(12'h018, 8'h00);
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_drive();
        t_pullup();
        t_change();
        t_override();
        t_strap();
        report_and_stop();
    end

    // The whole run needs about 240 cycles; this limit only catches a hang.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
